// ===== upe_endpoint_csr.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_defines.svh"
module upe_endpoint_csr (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // usb packet engine
   input wire upe_pkg::upe_link_evt_s evt_i,
   input wire logic [`UPE_NUM_EP-1:0] tx_pkt_held_i,
   input wire logic [`UPE_NUM_EP-1:0] rx_full_i,
   // cpu fifo port activity
   input wire upe_pkg::upe_cpu_fifo_s fifo_i,
   // controls to engine, dma and interrupt logic
   output upe_pkg::upe_ep0_out_s ep0_o,
   output upe_pkg::upe_ep_out_s ep_o
);
   localparam int N = `UPE_NUM_EP;

   logic take;
   logic [2:0] idx;

   upe_wb_slave u_slave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_adr_i(wb_adr_i),
      .wb_ack_o(wb_ack_o),
      .take_o(take),
      .idx_o(idx)
   );

   // byte lanes turn into a bit mask; unselected lanes are not written, except in the max payload registers, which take all bits
   wire logic [15:0] lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [15:0] w1 = wb_dat_i[15:0] & lane;
   wire logic [15:0] w0 = ~wb_dat_i[15:0] & lane;
   wire logic wr = take & wb_we_i;
   wire logic wr_sel = wr & (idx == `UPE_IDX_SEL);
   wire logic wr_ep0 = wr & (idx == `UPE_IDX_EP0);
   wire logic wr_tx = wr & (idx == `UPE_IDX_TXCSR);
   wire logic wr_txm = wr & (idx == `UPE_IDX_TXMAX);
   wire logic wr_rxm = wr & (idx == `UPE_IDX_RXMAX);
   wire logic wr_rx = wr & (idx == `UPE_IDX_RXCSR);

   logic [3:0] ep_sel_q;
   logic [3:0] ep_sel_d;
   assign ep_sel_d = (wr_sel & wb_sel_i[0]) ? wb_dat_i[3:0] : ep_sel_q; // see R23

   // endpoint 0 state
   logic tx0_q, rx0_q, stall0_q, sent0_q, setup_end_q, data_end_q, flush0_q, irq0_q;
   wire logic ev0 = (evt_i.ep == 4'h0);
   wire logic txdone0 = ev0 & evt_i.tx_done;
   wire logic rxdone0 = ev0 & evt_i.rx_done;
   wire logic stalled0 = ev0 & evt_i.stall_done;
   wire logic abort0 = ev0 & evt_i.ctrl_abort & ~data_end_q; // see R04
   wire logic flush0 = wr_ep0 & w1[`UPE_EP0_FLUSH] & (tx0_q | rx0_q); // see R01
   wire logic serv_rx0 = wr_ep0 & w1[`UPE_EP0_SERV_RX]; // see R02
   wire logic serv_su0 = wr_ep0 & w1[`UPE_EP0_SERV_SETUP]; // see R02
   // a stall ends the transaction, so the ready flags go with it
   wire logic kill0 = flush0 | abort0 | stalled0; // see R03
   wire logic tx0_d = (tx0_q & ~(txdone0 | kill0)) | (wr_ep0 & w1[`UPE_EP0_TX_READY]); // see R07
   wire logic rx0_d = (rx0_q & ~(serv_rx0 | kill0)) | rxdone0; // see R08
   wire logic stall0_d = (stall0_q & ~stalled0) | (wr_ep0 & w1[`UPE_EP0_SEND_STALL]); // see R03
   wire logic sent0_d = (sent0_q & ~(wr_ep0 & w0[`UPE_EP0_STALL_SENT])) | stalled0; // see R06
   wire logic setup_end_d = (setup_end_q & ~serv_su0) | abort0; // see R04
   wire logic data_end_d = (data_end_q & ~(ev0 & (evt_i.ctrl_done | evt_i.ctrl_abort)))
                           | (wr_ep0 & w1[`UPE_EP0_DATA_END]); // see R05
   wire logic irq0_d = (txdone0 & tx0_q) | rxdone0 | abort0; // see R07

   // non-zero endpoint state, bit e is endpoint e+1
   logic [15:0] tx_cfg_q [N];
   logic [15:0] rx_cfg_q [N];
   logic [15:0] tx_cfg_d [N];
   logic [15:0] rx_cfg_d [N];
   logic [`UPE_MAXP_W-1:0] txmax_q [N];
   logic [`UPE_MAXP_W-1:0] rxmax_q [N];
   logic [`UPE_MAXP_W-1:0] txmax_d [N];
   logic [`UPE_MAXP_W-1:0] rxmax_d [N];
   logic [15:0] tx_word [N];
   logic [15:0] rx_word [N];
   logic [N-1:0] txr_q, txr_d, rxr_q, rxr_d;
   logic [N-1:0] txs_q, txs_d, rxs_q, rxs_d;
   logic [N-1:0] und_q, und_d, ovr_q, ovr_d;
   logic [N-1:0] derr_q, derr_d, pid_q, pid_d;
   logic [N-1:0] txf_q, txf_d, rxf_q, rxf_d;
   logic [N-1:0] txi_q, txi_d, rxi_q, rxi_d;
   logic [N-1:0] tx_clr_tog, rx_clr_tog, tx_flip, rx_flip;
   logic [N-1:0] tx_tog, rx_tog;

   genvar e;
   generate
      for (e = 0; e < N; e++) begin : g_ep
         wire logic me = (ep_sel_q == 4'(e + 1));
         wire logic hit = (evt_i.ep == 4'(e + 1));
         wire logic wt = wr_tx & me;
         wire logic wrx = wr_rx & me;
         wire logic tiso = tx_cfg_q[e][`UPE_TX_ISO];
         wire logic riso = rx_cfg_q[e][`UPE_RX_ISO];
         wire logic tdone = hit & evt_i.tx_done;
         wire logic rdone = hit & evt_i.rx_done;
         wire logic tstall = hit & evt_i.stall_done & evt_i.dir_in;
         wire logic rstall = hit & evt_i.stall_done & ~evt_i.dir_in;
         wire logic tforce = wt & w1[`UPE_TX_FORCE_TOG];
         wire logic tflush = wt & w1[`UPE_TX_FLUSH] & txr_q[e]; // see R17
         wire logic rflush = wrx & w1[`UPE_RX_FLUSH] & rxr_q[e]; // see R17
         wire logic aset = tx_cfg_q[e][`UPE_TX_AUTO_SET] & fifo_i.load
                           & (fifo_i.ep == 4'(e + 1)) & (fifo_i.count == txmax_q[e]); // see R09
         wire logic aclr = rx_cfg_q[e][`UPE_RX_AUTO_CLEAR] & fifo_i.unload & rxr_q[e]
                           & (fifo_i.ep == 4'(e + 1)) & (fifo_i.count == rxmax_q[e]); // see R20
         wire logic tdrop = tdone | tflush | tstall | tforce; // see R14
         wire logic rdrop = (wrx & w0[`UPE_RX_READY]) | aclr | rflush | rstall;
         wire logic [15:0] tmask = `UPE_TX_CFG_MASK & lane;
         wire logic [15:0] rmask = `UPE_RX_CFG_MASK & lane;

         assign tx_cfg_d[e] = wt ? ((tx_cfg_q[e] & ~tmask) | (wb_dat_i[15:0] & tmask))
                                 : tx_cfg_q[e]; // see R10
         assign rx_cfg_d[e] = wrx ? ((rx_cfg_q[e] & ~rmask) | (wb_dat_i[15:0] & rmask))
                                  : rx_cfg_q[e]; // see R21
         assign txmax_d[e] = (wr_txm & me) ? wb_dat_i[`UPE_MAXP_W-1:0] : txmax_q[e]; // see R24
         assign rxmax_d[e] = (wr_rxm & me) ? wb_dat_i[`UPE_MAXP_W-1:0] : rxmax_q[e]; // see R20
         assign txr_d[e] = (txr_q[e] & ~tdrop) | (wt & w1[`UPE_TX_READY]) | aset; // see R07
         assign rxr_d[e] = (rxr_q[e] & ~rdrop) | rdone; // see R08
         assign txs_d[e] = (txs_q[e] & ~(wt & w0[`UPE_TX_STALL_SENT])) | tstall; // see R06
         assign rxs_d[e] = (rxs_q[e] & ~(wrx & w0[`UPE_RX_STALL_SENT])) | rstall; // see R06
         assign und_d[e] = (und_q[e] & ~(wt & w0[`UPE_TX_UNDERRUN]))
                           | (hit & evt_i.in_token & ~txr_q[e]); // see R18
         assign ovr_d[e] = (ovr_q[e] & ~(wrx & w0[`UPE_RX_OVERRUN]))
                           | (hit & evt_i.rx_no_room & riso); // see R22
         assign derr_d[e] = (derr_q[e] & ~rdrop) | (rdone & evt_i.rx_crc_err & riso); // see R22
         assign pid_d[e] = (pid_q[e] & ~rdrop) | (rdone & evt_i.rx_pid_err & riso); // see R21
         assign txf_d[e] = tflush | tstall | tforce; // see R06
         assign rxf_d[e] = rflush | rstall; // see R06
         // dma mode trades the per-packet interrupt for dma pacing
         assign txi_d[e] = tdone & txr_q[e] & ~tx_cfg_q[e][`UPE_TX_DMA_MODE]; // see R13
         assign rxi_d[e] = rdone; // see R08
         assign tx_clr_tog[e] = wt & w1[`UPE_TX_CLR_TOG]; // see R15
         assign rx_clr_tog[e] = wrx & w1[`UPE_RX_CLR_TOG]; // see R15
         assign tx_flip[e] = tdone | tforce; // see R14
         assign rx_flip[e] = rdone & ~evt_i.rx_crc_err;

         assign tx_word[e] = (tx_cfg_q[e] & `UPE_TX_CFG_MASK)
                             | {10'h000, txs_q[e], 2'b00, und_q[e],
                                tx_pkt_held_i[e], txr_q[e]}; // see R19
         // bulk endpoints read zero for the isochronous-only flags
         assign rx_word[e] = ((rx_cfg_q[e] & `UPE_RX_CFG_MASK & 16'hefff)
                             | {3'b000, riso ? pid_q[e] : rx_cfg_q[e][`UPE_RX_NO_NYET], 12'h000})
                             | {9'h000, rxs_q[e], rx_cfg_q[e][`UPE_RX_SEND_STALL], 1'b0,
                                derr_q[e] & riso, ovr_q[e] & riso,
                                rx_full_i[e], rxr_q[e]}; // see R22
      end
   endgenerate

   upe_toggle_bank u_tx_tog (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(tx_clr_tog),
      .flip_i(tx_flip),
      .tog_o(tx_tog)
   );

   upe_toggle_bank u_rx_tog (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(rx_clr_tog),
      .flip_i(rx_flip),
      .tog_o(rx_tog)
   );

   // read selection by endpoint select; absent endpoints read zero
   wire logic ep_ok = (ep_sel_q != 4'h0) & (ep_sel_q <= 4'(N));
   wire logic [1:0] ep_ix = 2'(ep_sel_q - 4'h1);
   wire logic [15:0] ep0_word = {7'h00, 3'b000, stall0_q, setup_end_q, data_end_q,
                                 sent0_q, tx0_q, rx0_q};
   wire logic [15:0] rd_word =
      (idx == `UPE_IDX_SEL) ? {12'h000, ep_sel_q} :
      (idx == `UPE_IDX_EP0) ? ep0_word :
      !ep_ok ? 16'h0000 :
      (idx == `UPE_IDX_TXCSR) ? tx_word[ep_ix] :
      (idx == `UPE_IDX_TXMAX) ? {5'h00, txmax_q[ep_ix]} :
      (idx == `UPE_IDX_RXMAX) ? {5'h00, rxmax_q[ep_ix]} :
      (idx == `UPE_IDX_RXCSR) ? rx_word[ep_ix] : 16'h0000;

   logic [15:0] rd_q;
   assign wb_dat_o = {16'h0000, rd_q};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= 16'h0000;
         ep_sel_q <= 4'h0;
      end else if (ce_i) begin
         if (take) begin
            rd_q <= rd_word;
         end
         ep_sel_q <= ep_sel_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {tx0_q, rx0_q, stall0_q, sent0_q} <= 4'h0;
         {setup_end_q, data_end_q, flush0_q, irq0_q} <= 4'h0;
      end else if (ce_i) begin
         {tx0_q, rx0_q, stall0_q, sent0_q} <= {tx0_d, rx0_d, stall0_d, sent0_d};
         {setup_end_q, data_end_q} <= {setup_end_d, data_end_d};
         flush0_q <= flush0 | abort0; // see R01
         irq0_q <= irq0_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {txr_q, rxr_q, txs_q, rxs_q} <= '0;
         {und_q, ovr_q, derr_q, pid_q} <= '0;
         {txf_q, rxf_q, txi_q, rxi_q} <= '0;
      end else if (ce_i) begin
         {txr_q, rxr_q, txs_q, rxs_q} <= {txr_d, rxr_d, txs_d, rxs_d};
         {und_q, ovr_q, derr_q, pid_q} <= {und_d, ovr_d, derr_d, pid_d};
         {txf_q, rxf_q, txi_q, rxi_q} <= {txf_d, rxf_d, txi_d, rxi_d};
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < N; i++) begin
         if (rst_i) begin
            tx_cfg_q[i] <= `UPE_CSR_RESET;
            rx_cfg_q[i] <= `UPE_CSR_RESET;
            txmax_q[i] <= '0;
            rxmax_q[i] <= '0;
         end else if (ce_i) begin
            tx_cfg_q[i] <= tx_cfg_d[i];
            rx_cfg_q[i] <= rx_cfg_d[i];
            txmax_q[i] <= txmax_d[i];
            rxmax_q[i] <= rxmax_d[i];
         end
      end
   end

   assign ep0_o.tx_ready = tx0_q;
   assign ep0_o.rx_ready = rx0_q;
   assign ep0_o.stall = stall0_q; // see R03
   assign ep0_o.data_end = data_end_q;
   assign ep0_o.flush = flush0_q;
   assign ep0_o.irq = irq0_q;

   logic [N-1:0] tx_iso_v, rx_iso_v, tx_dir_v, nonyet_v, tx_st_v, rx_st_v, tx_den, rx_den;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         tx_iso_v[i] = tx_cfg_q[i][`UPE_TX_ISO];
         rx_iso_v[i] = rx_cfg_q[i][`UPE_RX_ISO];
         tx_dir_v[i] = tx_cfg_q[i][`UPE_TX_DIR];
         nonyet_v[i] = rx_cfg_q[i][`UPE_RX_NO_NYET];
         tx_st_v[i] = tx_cfg_q[i][`UPE_TX_SEND_STALL];
         rx_st_v[i] = rx_cfg_q[i][`UPE_RX_SEND_STALL];
         tx_den[i] = tx_cfg_q[i][`UPE_TX_DMA_EN];
         rx_den[i] = rx_cfg_q[i][`UPE_RX_DMA_EN];
      end
   end

   assign ep_o.tx_ready = txr_q;
   assign ep_o.rx_ready = rxr_q;
   assign ep_o.tx_stall = tx_st_v & ~tx_iso_v; // see R16
   assign ep_o.rx_stall = rx_st_v & ~rx_iso_v; // see R16
   assign ep_o.tx_iso = tx_iso_v; // see R10
   assign ep_o.rx_iso = rx_iso_v; // see R10
   assign ep_o.tx_dir = tx_dir_v; // see R11
   assign ep_o.no_nyet = nonyet_v & ~rx_iso_v; // see R21
   assign ep_o.tx_toggle = tx_tog;
   assign ep_o.rx_toggle = rx_tog;
   assign ep_o.tx_flush = txf_q;
   assign ep_o.rx_flush = rxf_q;
   assign ep_o.tx_dma_req = tx_den & ~txr_q; // see R12
   assign ep_o.rx_dma_req = rx_den & rxr_q; // see R12
   assign ep_o.tx_irq = txi_q;
   assign ep_o.rx_irq = rxi_q;
endmodule
`default_nettype wire

// ===== upe_defines.svh
// How it works
// R01 - ep0 flush write resets fifo pointer and clears set ready flag; else no effect
// R02 - ep0 service bits clear setup-end or receive-ready; they self-clear
// R03 - ep0 send-stall aborts transaction, stall goes out, then bit clears itself
// R04 - control transfer ending before data-end sets setup-end, interrupts, flushes fifo
// R05 - software sets ep0 data-end for last or zero-length packets; device clears it
// R06 - stall handshake sent sets stall-sent; non-zero endpoints also flush, drop ready
// R07 - transmit-ready set by software, cleared when packet sent, interrupt on clearing
// R08 - received packet sets receive-ready and interrupts; full flag when fifo cannot accept
// R09 - auto-set raises transmit-ready when exactly a maximum-size packet is loaded
// R10 - isochronous select bit chooses isochronous, else bulk or interrupt transfers
// R11 - direction bit picks transmit (1) or receive (0) on shared fifo endpoints
// R12 - dma request for an endpoint only while its dma-enable bit is set
// R13 - software sets transmit dma mode; clears receive dma mode before receive dma
// R14 - force-toggle switches data toggle and drops packet regardless of ack
// R15 - clear-toggle resets the endpoint data toggle to zero
// R16 - send-stall on non-zero endpoint stalls tokens until cleared; ignored when isochronous
// R17 - endpoint flush drops next packet, resets pointer, clears ready; needs ready set
// R18 - in token while transmit-ready clear sets sticky underrun flag
// R19 - not-empty flag shows at least one packet in the transmit fifo
// R20 - auto-clear drops receive-ready after maximum payload bytes unloaded; up to 1024
// R21 - no-nyet makes high-speed bulk receive ack all; isochronous reports packet_id_error there
// R22 - isochronous data-error follows receive-ready, overrun on lost packet; bulk reads zero
// R23 - four-bit endpoint select picks which endpoint registers appear in the map
// R24 - transmit maximum payload field is the size auto-set compares against
`ifndef UPE_DEFINES_SVH
`define UPE_DEFINES_SVH

`define UPE_NUM_EP 4
`define UPE_ADR_SEL 8'h00
`define UPE_ADR_EP0 8'h04
`define UPE_ADR_TXCSR 8'h08
`define UPE_ADR_TXMAX 8'h0c
`define UPE_ADR_RXMAX 8'h10
`define UPE_ADR_RXCSR 8'h14

`define UPE_IDX_SEL 3'h0
`define UPE_IDX_EP0 3'h1
`define UPE_IDX_TXCSR 3'h2
`define UPE_IDX_TXMAX 3'h3
`define UPE_IDX_RXMAX 3'h4
`define UPE_IDX_RXCSR 3'h5
`define UPE_IDX_NONE 3'h7

`define UPE_EP0_FLUSH 8
`define UPE_EP0_SERV_SETUP 7
`define UPE_EP0_SERV_RX 6
`define UPE_EP0_SEND_STALL 5
`define UPE_EP0_SETUP_END 4
`define UPE_EP0_DATA_END 3
`define UPE_EP0_STALL_SENT 2
`define UPE_EP0_TX_READY 1
`define UPE_EP0_RX_READY 0

`define UPE_TX_AUTO_SET 15
`define UPE_TX_ISO 14
`define UPE_TX_DIR 13
`define UPE_TX_DMA_EN 12
`define UPE_TX_FORCE_TOG 11
`define UPE_TX_DMA_MODE 10
`define UPE_TX_CLR_TOG 6
`define UPE_TX_STALL_SENT 5
`define UPE_TX_SEND_STALL 4
`define UPE_TX_FLUSH 3
`define UPE_TX_UNDERRUN 2
`define UPE_TX_NOT_EMPTY 1
`define UPE_TX_READY 0
`define UPE_TX_CFG_MASK 16'hf410

`define UPE_RX_AUTO_CLEAR 15
`define UPE_RX_ISO 14
`define UPE_RX_DMA_EN 13
`define UPE_RX_NO_NYET 12
`define UPE_RX_DMA_MODE 11
`define UPE_RX_CLR_TOG 7
`define UPE_RX_STALL_SENT 6
`define UPE_RX_SEND_STALL 5
`define UPE_RX_FLUSH 4
`define UPE_RX_DATA_ERR 3
`define UPE_RX_OVERRUN 2
`define UPE_RX_FULL 1
`define UPE_RX_READY 0
`define UPE_RX_CFG_MASK 16'hf820

`define UPE_MAXP_W 11
`define UPE_CSR_RESET 16'h0000

`endif

// ===== upe_pkg.sv
`include "upe_defines.svh"
package upe_pkg;
   // one event from the usb packet engine, its flags pulse for one cycle
   typedef struct packed {
      logic [3:0] ep;
      logic dir_in;
      logic tx_done;
      logic rx_done;
      logic rx_crc_err;
      logic rx_pid_err;
      logic rx_no_room;
      logic in_token;
      logic stall_done;
      logic ctrl_abort;
      logic ctrl_done;
   } upe_link_evt_s;

   // cpu side fifo port activity with running byte count of the packet
   typedef struct packed {
      logic [3:0] ep;
      logic load;
      logic unload;
      logic [`UPE_MAXP_W-1:0] count;
   } upe_cpu_fifo_s;

   typedef struct packed {
      logic tx_ready;
      logic rx_ready;
      logic stall;
      logic data_end;
      logic flush;
      logic irq;
   } upe_ep0_out_s;

   typedef struct packed {
      logic [`UPE_NUM_EP-1:0] tx_ready;
      logic [`UPE_NUM_EP-1:0] rx_ready;
      logic [`UPE_NUM_EP-1:0] tx_stall;
      logic [`UPE_NUM_EP-1:0] rx_stall;
      logic [`UPE_NUM_EP-1:0] tx_iso;
      logic [`UPE_NUM_EP-1:0] rx_iso;
      logic [`UPE_NUM_EP-1:0] tx_dir;
      logic [`UPE_NUM_EP-1:0] no_nyet;
      logic [`UPE_NUM_EP-1:0] tx_toggle;
      logic [`UPE_NUM_EP-1:0] rx_toggle;
      logic [`UPE_NUM_EP-1:0] tx_flush;
      logic [`UPE_NUM_EP-1:0] rx_flush;
      logic [`UPE_NUM_EP-1:0] tx_dma_req;
      logic [`UPE_NUM_EP-1:0] rx_dma_req;
      logic [`UPE_NUM_EP-1:0] tx_irq;
      logic [`UPE_NUM_EP-1:0] rx_irq;
   } upe_ep_out_s;
endpackage

// ===== upe_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_defines.svh"
module upe_wb_slave (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone request
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_adr_i,
   // decode
   output logic wb_ack_o,
   output logic take_o,
   output logic [2:0] idx_o
);
   logic ack_q;
   wire logic page_hit = (wb_adr_i[31:8] == 24'h000000);
   wire logic [7:0] low = wb_adr_i[7:0];

   // one new access per request, ack stands one cycle
   assign take_o = wb_cyc_i & wb_stb_i & ~ack_q & ce_i;
   assign wb_ack_o = ack_q;
   assign idx_o = !page_hit ? `UPE_IDX_NONE :
                  (low == `UPE_ADR_SEL) ? `UPE_IDX_SEL :
                  (low == `UPE_ADR_EP0) ? `UPE_IDX_EP0 :
                  (low == `UPE_ADR_TXCSR) ? `UPE_IDX_TXCSR :
                  (low == `UPE_ADR_TXMAX) ? `UPE_IDX_TXMAX :
                  (low == `UPE_ADR_RXMAX) ? `UPE_IDX_RXMAX :
                  (low == `UPE_ADR_RXCSR) ? `UPE_IDX_RXCSR : `UPE_IDX_NONE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= take_o;
      end
   end
endmodule
`default_nettype wire

// ===== upe_toggle_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_defines.svh"
module upe_toggle_bank (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // per endpoint controls
   input wire logic [`UPE_NUM_EP-1:0] clr_i,
   input wire logic [`UPE_NUM_EP-1:0] flip_i,
   output logic [`UPE_NUM_EP-1:0] tog_o
);
   logic [`UPE_NUM_EP-1:0] tog_q;
   // software clear wins over a flip in the same cycle
   wire logic [`UPE_NUM_EP-1:0] tog_d = ~clr_i & (tog_q ^ flip_i); // see R15

   assign tog_o = tog_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tog_q <= '0;
      end else if (ce_i) begin
         tog_q <= tog_d;
      end
   end
endmodule
`default_nettype wire

// ===== upe_csr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_defines.svh"
module upe_csr_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   // engine and cpu side
   input wire upe_pkg::upe_link_evt_s evt_i,
   input wire upe_pkg::upe_cpu_fifo_s fifo_i,
   input wire upe_pkg::upe_ep0_out_s ep0_o,
   input wire upe_pkg::upe_ep_out_s ep_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a write or load on the same edge may set a flag, and set wins
   wire logic wr = (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) || fifo_i.load;
   wire logic inr = ce_i && evt_i.ep != 4'h0 && evt_i.ep <= 4'(`UPE_NUM_EP);
   wire logic [1:0] idx = 2'(evt_i.ep - 4'h1);
   property p_ack;
      ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("request not acked");
   property p_ack_pulse;
      ce_i && wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   property p_rx_set;
      inr && evt_i.rx_done |=> ep_o.rx_ready[$past(idx)] && ep_o.rx_irq[$past(idx)];
   endproperty
   a_rx_set: assert property (p_rx_set) else $error("rx ready not set");
   property p_ep0_rx;
      ce_i && evt_i.rx_done && evt_i.ep == 4'h0 |=> ep0_o.rx_ready && ep0_o.irq;
   endproperty
   a_ep0_rx: assert property (p_ep0_rx) else $error("ep0 rx ready not set");
   property p_tx_done;
      inr && evt_i.tx_done && !wr |=> !ep_o.tx_ready[$past(idx)];
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("tx ready kept");
   property p_stall;
      inr && evt_i.stall_done && evt_i.dir_in && !wr |=>
         ep_o.tx_flush[$past(idx)] && !ep_o.tx_ready[$past(idx)];
   endproperty
   a_stall: assert property (p_stall) else $error("stall without flush");
   property p_abort;
      ce_i && evt_i.ctrl_abort && evt_i.ep == 4'h0 && !ep0_o.data_end && !wr |=>
         ep0_o.flush && ep0_o.irq && !ep0_o.data_end;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not handled");
   property p_dma;
      (ep_o.tx_dma_req & ep_o.tx_ready) == '0 && (ep_o.rx_dma_req & ~ep_o.rx_ready) == '0;
   endproperty
   a_dma: assert property (p_dma) else $error("dma request wrong");
   property p_iso;
      ((ep_o.tx_stall & ep_o.tx_iso) | (ep_o.rx_stall | ep_o.no_nyet) & ep_o.rx_iso) == '0;
   endproperty
   a_iso: assert property (p_iso) else $error("iso endpoint stalls");
endmodule
bind upe_endpoint_csr upe_csr_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
   .evt_i(evt_i), .fifo_i(fifo_i), .ep0_o(ep0_o), .ep_o(ep_o));
`default_nettype wire

// ===== upe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_defines.svh"
module upe_host_model (
   // clock
   input wire logic clk_i,
   // endpoint state
   input wire upe_pkg::upe_ep_out_s ep_i,
   // engine events
   output var upe_pkg::upe_link_evt_s evt_o,
   output logic [`UPE_NUM_EP-1:0] held_o,
   output logic [`UPE_NUM_EP-1:0] full_o
);
   initial evt_o = '0;
   // single-buffered fifos: one ready packet fills them
   assign held_o = ep_i.tx_ready;
   assign full_o = ep_i.rx_ready;
   task automatic pulse(input upe_pkg::upe_link_evt_s v);
      evt_o <= v;
      @(posedge clk_i);
      evt_o <= '0;
      @(posedge clk_i);
   endtask
   // a stalled endpoint answers the token at once, no token event
   task automatic in_tok(input int e);
      logic st;
      logic rd;
      st = ep_i.tx_stall[e-1];
      rd = ep_i.tx_ready[e-1];
      if (st) pulse('{ep: 4'(e), dir_in: 1'b1, stall_done: 1'b1, default: 1'b0});
      else pulse('{ep: 4'(e), in_token: 1'b1, default: 1'b0});
      if (!st && rd) pulse('{ep: 4'(e), tx_done: 1'b1, default: 1'b0});
   endtask
endmodule
`default_nettype wire

// ===== upe_endpoint_csr_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_defines.svh"
module upe_endpoint_csr_tb;
   logic clk_i, rst_i, cyc, stb, we, ack;
   logic [31:0] adr, wdat, rdat;
   logic [3:0] sel, held, full;
   upe_pkg::upe_link_evt_s evt;
   upe_pkg::upe_cpu_fifo_s fifo;
   upe_pkg::upe_ep0_out_s ep0;
   upe_pkg::upe_ep_out_s ep;
   int n_mismatch = 0;
   int check_count = 0;
   logic [10:0] m;
   logic [15:0] q;
   upe_endpoint_csr dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .evt_i(evt), .tx_pkt_held_i(held),
      .rx_full_i(full), .fifo_i(fifo), .ep0_o(ep0), .ep_o(ep));
   upe_host_model mdl (.clk_i(clk_i), .ep_i(ep), .evt_o(evt), .held_o(held), .full_o(full));
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      check_count++;
      if (s !== x) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      {cyc, stb, we} <= {2'b11, w};
      adr <= {24'h0, a};
      wdat <= {16'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[15:0];
      {cyc, stb} <= 2'b00;
      if (ack !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] x);
      wb(1'b0, a, 16'h0);
      chk(q, x);
   endtask
   task automatic fifo_op(input logic ld, input int e, input logic [10:0] c);
      fifo <= '{ep: 4'(e), load: ld, unload: !ld, count: c};
      @(posedge clk_i);
      fifo <= '0;
      @(posedge clk_i);
   endtask
   // not-empty follows the model's held level, i.e. tx ready
   function automatic logic [15:0] tx_exp(input logic [15:0] c, input logic r, input logic u);
      return c | {13'h0, u, r, r};
   endfunction
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we} = 3'b000;
      adr = '0;
      wdat = '0;
      sel = 4'h3;
      fifo = '0;
      void'($urandom(32'h3bd8));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b1, 8'h00, 16'h0001);
      for (int a = 4; a <= 24; a += 4) rdc(8'(a), 16'h0000);
      mdl.pulse('{ep: 4'h0, rx_done: 1'b1, default: 1'b0});
      rdc(8'h04, 16'h0001);
      wb(1'b1, 8'h04, 16'h0040);
      rdc(8'h04, 16'h0000);
      wb(1'b1, 8'h04, 16'h000a);
      rdc(8'h04, 16'h000a);
      mdl.pulse('{ep: 4'h0, tx_done: 1'b1, default: 1'b0});
      rdc(8'h04, 16'h0008);
      mdl.pulse('{ep: 4'h0, ctrl_done: 1'b1, default: 1'b0});
      mdl.pulse('{ep: 4'h0, ctrl_abort: 1'b1, default: 1'b0});
      rdc(8'h04, 16'h0010);
      wb(1'b1, 8'h04, 16'h00a0);
      chk(16'(ep0.stall), 16'h0001);
      mdl.pulse('{ep: 4'h0, stall_done: 1'b1, default: 1'b0});
      rdc(8'h04, 16'h0004);
      mdl.pulse('{ep: 4'h0, rx_done: 1'b1, default: 1'b0});
      wb(1'b1, 8'h04, 16'h0100);
      rdc(8'h04, 16'h0000);
      for (int e = 1; e <= 4; e++) begin
         m = 11'($urandom_range(1024, 2));
         wb(1'b1, 8'h00, 16'(e));
         wb(1'b1, 8'h14, 16'h4000);
         mdl.pulse('{ep: 4'(e), rx_done: 1'b1, rx_crc_err: 1'b1, default: 1'b0});
         rdc(8'h14, 16'h400b);
         wb(1'b1, 8'h10, 16'(m));
         rdc(8'h10, 16'(m));
         wb(1'b1, 8'h14, 16'hc001);
         fifo_op(1'b0, e, m - 11'h1);
         rdc(8'h14, 16'hc00b);
         fifo_op(1'b0, e, m);
         rdc(8'h14, 16'hc000);
         wb(1'b1, 8'h14, 16'h1000);
         chk(16'(ep.no_nyet[e-1]), 16'h0001);
         wb(1'b1, 8'h14, 16'h5020);
         chk(16'({ep.no_nyet[e-1], ep.rx_stall[e-1]}), 16'h0000);
         wb(1'b1, 8'h14, 16'h0020);
         mdl.pulse('{ep: 4'(e), stall_done: 1'b1, default: 1'b0});
         rdc(8'h14, 16'h0060);
         wb(1'b1, 8'h0c, 16'(m));
         wb(1'b1, 8'h08, 16'h8000);
         fifo_op(1'b1, e, m - 11'h1);
         rdc(8'h08, tx_exp(16'h8000, 1'b0, 1'b0));
         fifo_op(1'b1, e, m);
         rdc(8'h08, tx_exp(16'h8000, 1'b1, 1'b0));
         mdl.in_tok(e);
         rdc(8'h08, tx_exp(16'h8000, 1'b0, 1'b0));
         mdl.in_tok(e);
         rdc(8'h08, tx_exp(16'h8000, 1'b0, 1'b1));
         wb(1'b1, 8'h08, 16'h1400);
         chk(16'(ep.tx_dma_req[e-1]), 16'h0001);
         wb(1'b1, 8'h08, 16'h0010);
         mdl.in_tok(e);
         rdc(8'h08, 16'h0030);
         wb(1'b1, 8'h08, 16'h0040);
         chk(16'(ep.tx_toggle[e-1]), 16'h0000);
         wb(1'b1, 8'h08, 16'h0800);
         chk(16'(ep.tx_toggle[e-1]), 16'h0001);
      end
      wb(1'b1, 8'h00, 16'h0005);
      rdc(8'h08, 16'h0000);
      test_done();
   end
endmodule
`default_nettype wire
